// *** hw/video_rx_ctrl_regs.svh ***
// Purpose: offsets, fields, reset values and timing counts of video_rx_ctrl
// Assumes: 32-bit Avalon-MM data, byte addresses, one word per register
// Notes: definitions only
`ifndef VIDEO_RX_CTRL_REGS_SVH
`define VIDEO_RX_CTRL_REGS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define VRX_ADDR_W 4
`define VRX_REG_CTRL 4'h0
`define VRX_REG_STATUS 4'h4
`define VRX_REG_MASK 4'h8
`define VRX_REG_STATE 4'hC
`define VRX_CTRL_BYPASS 0
`define VRX_EVT_W 4
`define VRX_EVT_CLK_LOST 0
`define VRX_EVT_CLK_BACK 1
`define VRX_EVT_VID_UP 2
`define VRX_EVT_VID_DOWN 3
`define VRX_ST_LOW_POWER 0
`define VRX_ST_PRESENT 1
`define VRX_ST_SMOOTH 2
`define VRX_ST_SHUTDOWN 3
`define VRX_CTRL_RST 1'h0
`define VRX_MASK_RST 4'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define VRX_MCLK_MHZ 250
`define VRX_CLK_LOSS_NS 1000
`define VRX_CLK_LOSS_CYC ((`VRX_CLK_LOSS_NS * `VRX_MCLK_MHZ + 999) / 1000)
`define VRX_DE_IDLE_US 100
`define VRX_DE_IDLE_CYC (`VRX_DE_IDLE_US * `VRX_MCLK_MHZ)
`define VRX_SMOOTH_PHASES 8
`define VRX_PIX_W 24

`endif

// *** hw/video_rx_ctrl_pkg.sv ***
// Purpose: types shared by the video receiver control logic
// Assumes: video_rx_ctrl_regs.svh included first
// Notes: none
`include "video_rx_ctrl_regs.svh"

package video_rx_ctrl_pkg;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic de;
    logic [`VRX_PIX_W-1:0] data;
  } video_s;

  typedef enum logic {PWR_ACTIVE, PWR_LOW} power_e;

endpackage : video_rx_ctrl_pkg

// *** hw/video_rx_ctrl.sv ***
// Purpose: line sync smoothing, clock-loss power down and video presence detect
// Assumes: pixel clock and video pins sampled by mclk, well above the pixel rate
// Notes: weak pull-downs sit in the pads; the core only drops the enables
// Behaviour
// - strap low enables the line sync smoothing stage, strap high bypasses it.
// - with smoothing on, sync output lags data by 0 to 7 pixel clocks.
// - enter low power automatically when no pixel clock arrives.
// - in low power everything but the clock detector and the register bus with its interrupt is held idle.
// - in low power the video, present flag and aux outputs stop driving; pads pull them low.
// - video present flag low whenever data enable is inactive.
// - in low power the video present flag is not driven.
// - video present flag high while data enable toggles.
// - output shutdown low releases outputs except present flag and aux control.
// - an unconnected strap, pulled high, leaves smoothing disabled.
`timescale 1ns/1ns
`default_nettype none
`include "video_rx_ctrl_regs.svh"

module video_rx_ctrl #(
  parameter int DE_IDLE_CYCLES = `VRX_DE_IDLE_CYC,
  parameter int CLK_LOSS_CYCLES = `VRX_CLK_LOSS_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic pixClk,
  input wire video_rx_ctrl_pkg::video_s vidIn,
  input wire logic auxCtlIn,
  input wire logic line_sync_smoothing_en_n,
  input wire logic output_shutdown_n,
  output var video_rx_ctrl_pkg::video_s vidOut,
  output logic vidOe,
  output logic video_present_flag,
  output logic presentOe,
  output logic aux_control_out_1,
  output logic auxOe,
  input wire logic [`VRX_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);

  localparam int DE_W = $clog2(DE_IDLE_CYCLES + 1);
  localparam int CL_W = $clog2(CLK_LOSS_CYCLES + 1);
  localparam int PH_W = $clog2(`VRX_SMOOTH_PHASES);
  localparam logic [DE_W-1:0] DE_LIMIT = DE_W'(DE_IDLE_CYCLES);
  localparam logic [CL_W-1:0] CL_LIMIT = CL_W'(CLK_LOSS_CYCLES);

  if (DE_IDLE_CYCLES < 2 || CLK_LOSS_CYCLES < 2) begin : g_bad_param
    $error("video_rx_ctrl: idle counts must be at least 2");
  end

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] pinS1_reg, pinS2_reg, pinS1_next, pinS2_next;
  video_rx_ctrl_pkg::video_s vidS1_reg, vidS2_reg, vidS1_next, vidS2_next;
  logic pixClkD_reg, pixClkD_next;

  always_comb begin
    pinS1_next = {pixClk, auxCtlIn, line_sync_smoothing_en_n, output_shutdown_n};
    pinS2_next = pinS1_reg;
    vidS1_next = vidIn;
    vidS2_next = vidS1_reg;
    pixClkD_next = pinS2_reg[3];
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pinS1_reg <= 4'h7;
      pinS2_reg <= 4'h7;
      vidS1_reg <= '0;
      vidS2_reg <= '0;
      pixClkD_reg <= 1'b0;
    end else begin
      pinS1_reg <= pinS1_next;
      pinS2_reg <= pinS2_next;
      vidS1_reg <= vidS1_next;
      vidS2_reg <= vidS2_next;
      pixClkD_reg <= pixClkD_next;
    end
  end

  logic pixEdge, auxS, strapN, shutdownN;
  assign pixEdge = pinS2_reg[3] && !pixClkD_reg;
  assign auxS = pinS2_reg[2];
  assign strapN = pinS2_reg[1];
  assign shutdownN = pinS2_reg[0];

  // ----------------------------------------------------------------------
  // clock detector and power state
  // ----------------------------------------------------------------------
  video_rx_ctrl_pkg::power_e pwr_reg, pwr_next;
  logic [CL_W-1:0] clkIdle_reg, clkIdle_next;
  logic clkLost, clkBack, lowPower;

  always_comb begin
    clkIdle_next = clkIdle_reg;
    pwr_next = pwr_reg;
    clkLost = 1'b0;
    clkBack = 1'b0;
    if (pixEdge) begin
      clkIdle_next = '0;
    end else if (clkIdle_reg != CL_LIMIT) begin
      clkIdle_next = clkIdle_reg + CL_W'(1);
    end
    unique case (pwr_reg)
      video_rx_ctrl_pkg::PWR_ACTIVE: begin
        if (clkIdle_reg == CL_LIMIT) begin
          pwr_next = video_rx_ctrl_pkg::PWR_LOW;
          clkLost = 1'b1;
        end
      end
      video_rx_ctrl_pkg::PWR_LOW: begin
        if (pixEdge) begin
          pwr_next = video_rx_ctrl_pkg::PWR_ACTIVE;
          clkBack = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      clkIdle_reg <= '0;
      pwr_reg <= video_rx_ctrl_pkg::PWR_ACTIVE;
    end else begin
      clkIdle_reg <= clkIdle_next;
      pwr_reg <= pwr_next;
    end
  end

  assign lowPower = (pwr_reg == video_rx_ctrl_pkg::PWR_LOW);

  // ----------------------------------------------------------------------
  // video path with line sync smoothing
  // ----------------------------------------------------------------------
  logic bypassSw_reg;
  logic smoothOn;
  logic [PH_W-1:0] phase_reg, phase_next;
  video_rx_ctrl_pkg::video_s vid_reg, vid_next;

  // a floating strap reads high through the pad pull-up, so smoothing stays off
  assign smoothOn = !strapN && !bypassSw_reg;

  always_comb begin
    vid_next = vid_reg;
    phase_next = phase_reg;
    if (lowPower) begin
      vid_next = '0;
      phase_next = '0;
    end else if (pixEdge) begin
      phase_next = phase_reg + PH_W'(1);
      vid_next = vidS2_reg;
      // sync edges wait for the next eight-pixel boundary: 0..7 pixels late
      if (smoothOn && phase_reg != '0) begin
        vid_next.hsync = vid_reg.hsync;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      vid_reg <= '0;
      phase_reg <= '0;
    end else begin
      vid_reg <= vid_next;
      phase_reg <= phase_next;
    end
  end

  // ----------------------------------------------------------------------
  // data enable activity
  // ----------------------------------------------------------------------
  logic deD_reg, deD_next;
  logic [DE_W-1:0] deIdle_reg, deIdle_next;
  logic present_reg, present_next;

  always_comb begin
    deD_next = vidS2_reg.de;
    deIdle_next = deIdle_reg;
    if (lowPower) begin
      deIdle_next = DE_LIMIT;
    end else if (vidS2_reg.de != deD_reg) begin
      deIdle_next = '0;
    end else if (deIdle_reg != DE_LIMIT) begin
      deIdle_next = deIdle_reg + DE_W'(1);
    end
    present_next = (deIdle_reg != DE_LIMIT);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      deD_reg <= 1'b0;
      deIdle_reg <= DE_LIMIT;
      present_reg <= 1'b0;
    end else begin
      deD_reg <= deD_next;
      deIdle_reg <= deIdle_next;
      present_reg <= present_next;
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------
  logic vidOe_next, presentOe_next, auxOe_next;

  always_comb begin
    vidOe_next = !lowPower && shutdownN;
    presentOe_next = !lowPower;
    auxOe_next = !lowPower;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      vidOut <= '0;
      vidOe <= 1'b0;
      video_present_flag <= 1'b0;
      presentOe <= 1'b0;
      aux_control_out_1 <= 1'b0;
      auxOe <= 1'b0;
    end else begin
      vidOut <= vid_reg;
      vidOe <= vidOe_next;
      video_present_flag <= present_reg;
      presentOe <= presentOe_next;
      aux_control_out_1 <= auxS && !lowPower;
      auxOe <= auxOe_next;
    end
  end

  // ----------------------------------------------------------------------
  // register bus and interrupt
  // ----------------------------------------------------------------------
  logic [`VRX_EVT_W-1:0] status_reg, status_next, mask_reg, mask_next, events;
  logic bypassSw_next, wait_next, irq_next, req, take;
  logic [31:0] rdata_next;

  assign req = avs_read || avs_write;
  assign take = req && !avs_waitrequest;
  assign events = {present_reg && !present_next, !present_reg && present_next,
                   clkBack, clkLost};

  always_comb begin
    wait_next = !(req && avs_waitrequest);
    bypassSw_next = bypassSw_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    rdata_next = avs_readdata;
    if (take && avs_write) begin
      unique case (avs_address)
        `VRX_REG_CTRL: bypassSw_next = avs_writedata[`VRX_CTRL_BYPASS];
        `VRX_REG_STATUS: status_next = status_reg & ~avs_writedata[`VRX_EVT_W-1:0];
        `VRX_REG_MASK: mask_next = avs_writedata[`VRX_EVT_W-1:0];
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    status_next = status_next | events;
    if (req && avs_waitrequest && avs_read) begin
      rdata_next = 32'h0000_0000;
      unique case (avs_address)
        `VRX_REG_CTRL: rdata_next[`VRX_CTRL_BYPASS] = bypassSw_reg;
        `VRX_REG_STATUS: rdata_next[`VRX_EVT_W-1:0] = status_reg;
        `VRX_REG_MASK: rdata_next[`VRX_EVT_W-1:0] = mask_reg;
        `VRX_REG_STATE: rdata_next[3:0] = {!shutdownN, smoothOn, present_reg, lowPower};
        default: ;
      endcase
    end
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      bypassSw_reg <= `VRX_CTRL_RST;
      mask_reg <= `VRX_MASK_RST;
      status_reg <= '0;
      irq <= 1'b0;
    end else begin
      avs_waitrequest <= wait_next;
      avs_readdata <= rdata_next;
      bypassSw_reg <= bypassSw_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
      irq <= irq_next;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_clock_gone;
    !lowPower && clkIdle_reg == CL_LIMIT;
  endsequence
  sequence s_clock_back;
    lowPower && pixEdge;
  endsequence
  sequence s_de_quiet;
    !lowPower && deIdle_reg == DE_LIMIT;
  endsequence

  a_power_entry: assert property (s_clock_gone |=> lowPower ##1 !vidOe && !presentOe)
    else $error("no low power after clock loss");
  a_power_wake: assert property (s_clock_back |=> !lowPower ##1 presentOe && auxOe)
    else $error("no wake on clock resume");
  a_low_tristate: assert property (lowPower && $past(lowPower) |-> !vidOe && !presentOe && !auxOe)
    else $error("output driven in low power");
  a_low_idle: assert property (lowPower |=> vid_reg == '0 && deIdle_reg == DE_LIMIT)
    else $error("logic active in low power");
  a_bypass_path: assert property (!lowPower && pixEdge && !smoothOn |=>
      vid_reg.hsync == $past(vidS2_reg.hsync))
    else $error("bypassed sync not passed through");
  a_smooth_hold: assert property (!lowPower && pixEdge && smoothOn && phase_reg != '0 |=>
      $stable(vid_reg.hsync))
    else $error("sync moved off the eight pixel grid");
  a_present_low: assert property (s_de_quiet |=> ##1 !video_present_flag)
    else $error("present flag high with idle enable");
  a_present_high: assert property (!lowPower && vidS2_reg.de != deD_reg |=> ##2 video_present_flag)
    else $error("present flag low with toggling enable");
  a_shutdown_keep: assert property (!lowPower && !shutdownN |=> !vidOe && presentOe)
    else $error("shutdown drove wrong pins");
  a_bus_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

endmodule : video_rx_ctrl
`default_nettype wire

// *** test/video_source_model.sv ***
// Purpose: pixel clock and video source standing for the link transmitter
// Assumes: 125 ns pixel period, 16-pixel lines
// Notes: clock stands low while stopped
`timescale 1ns/1ns
`default_nettype none

module video_source_model (
  input wire logic run,
  input wire logic deOn,
  output logic pixClk,
  output var video_rx_ctrl_pkg::video_s vid
);
  logic [3:0] pos;

  initial begin
    pixClk = 1'b0;
    pos = 4'h0;
    vid = '0;
  end

  // ----------------------------------------------------------------------
  // pixel stream
  // ----------------------------------------------------------------------
  // porch and sync spans of eight pixels keep the smoothing grid valid
  always begin
    #62;
    pixClk = run;
    #63;
    pixClk = 1'b0;
    if (run) begin
      pos = pos + 4'h1;
      vid.de = deOn && !pos[3];
      vid.hsync = pos[3];
      vid.data = {20'h0, pos};
    end
  end
endmodule : video_source_model

`default_nettype wire

// *** test/video_rx_ctrl_test.sv ***
// Purpose: self-checking bench of video_rx_ctrl
// Assumes: short idle and loss counts set by parameter
// Notes: undriven pins modelled as pulled low
`timescale 1ns/1ns
`default_nettype none
`include "video_rx_ctrl_regs.svh"

module video_rx_ctrl_test;
  localparam int DE_IDLE = 600;
  localparam int LOSS = 80;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic run = 1'b1;
  logic deOn = 1'b1;
  logic pixClk;
  logic auxCtlIn = 1'b1;
  logic strapN = 1'b0;
  logic shutN = 1'b1;
  logic loopBack = 1'b0;
  logic presentPin;
  logic shutPin;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic vidOe;
  logic flag;
  logic presentOe;
  logic auxOut;
  logic auxOe;
  logic [31:0] q;
  int mismatches = 0;
  int samples_checked = 0;
  video_rx_ctrl_pkg::video_s vidIn;
  video_rx_ctrl_pkg::video_s vidOut;
  video_rx_ctrl_pkg::video_s vidPin;

  always #2 mclk = ~mclk;
  // released pins settle at the pad pull-down level
  assign vidPin = vidOe ? vidOut : '0;
  assign presentPin = presentOe ? flag : 1'b0;
  assign shutPin = loopBack ? presentPin : shutN;

  video_source_model i_src (.run(run), .deOn(deOn), .pixClk(pixClk), .vid(vidIn));

  video_rx_ctrl #(.DE_IDLE_CYCLES(DE_IDLE), .CLK_LOSS_CYCLES(LOSS)) i_dut (
    .mclk(mclk), .rst_b(rst_b), .pixClk(pixClk), .vidIn(vidIn), .auxCtlIn(auxCtlIn),
    .line_sync_smoothing_en_n(strapN), .output_shutdown_n(shutPin), .vidOut(vidOut),
    .vidOe(vidOe), .video_present_flag(flag), .presentOe(presentOe),
    .aux_control_out_1(auxOut), .auxOe(auxOe), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd

  task automatic results;
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  initial begin
    #60000;
    mismatches++;
    results();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`VRX_REG_CTRL, 32'h0);
    rd(`VRX_REG_MASK, 32'h0);
    bus(1'b1, `VRX_REG_MASK, 32'hFFFFFFFF);
    rd(`VRX_REG_MASK, 32'hF);
    bus(1'b1, `VRX_REG_MASK, 32'h0);
    bus(1'b1, 4'h2, 32'hF);
    rd(4'h2, 32'h0);
    $display("registers done");
    repeat (1000) @(posedge mclk);
    check(flag, 1'b1);
    check({vidOe, presentOe, auxOe}, 3'h7);
    rd(`VRX_REG_STATE, 32'h6);
    bus(1'b1, `VRX_REG_STATUS, 32'hF);
    rd(`VRX_REG_STATUS, 32'h0);
    repeat (20) begin
      repeat (9) @(posedge mclk);
      check(vidPin.hsync, vidPin.data[3]);
    end
    strapN <= 1'b1;
    repeat (10) @(posedge mclk);
    rd(`VRX_REG_STATE, 32'h2);
    repeat (20) begin
      repeat (9) @(posedge mclk);
      check(vidPin.hsync, vidPin.data[3]);
    end
    $display("smoothing done");
    shutN <= 1'b0;
    repeat (10) @(posedge mclk);
    check({vidOe, presentOe, auxOe, auxOut, flag}, 5'h0F);
    rd(`VRX_REG_STATE, 32'hA);
    shutN <= 1'b1;
    $display("shutdown done");
    bus(1'b1, `VRX_REG_MASK, 32'h8);
    deOn <= 1'b0;
    loopBack <= 1'b1;
    repeat (DE_IDLE + 200) @(posedge mclk);
    check({flag, presentOe, irq}, 3'h3);
    check(vidOe, 1'b0);
    rd(`VRX_REG_STATUS, 32'h8);
    bus(1'b1, `VRX_REG_STATUS, 32'h8);
    repeat (3) @(posedge mclk);
    check(irq, 1'b0);
    deOn <= 1'b1;
    repeat (1000) @(posedge mclk);
    check(flag, 1'b1);
    check(vidOe, 1'b1);
    loopBack <= 1'b0;
    $display("presence done");
    bus(1'b1, `VRX_REG_MASK, 32'h3);
    run <= 1'b0;
    repeat (LOSS + 20) @(posedge mclk);
    check({vidOe, presentOe, auxOe, irq}, 4'h1);
    check(vidPin, '0);
    check(vidOut, '0);
    check(presentOe, 1'b0);
    rd(`VRX_REG_STATE, 32'h1);
    rd(`VRX_REG_STATUS, 32'hD);
    bus(1'b1, `VRX_REG_STATUS, 32'hF);
    run <= 1'b1;
    repeat (200) @(posedge mclk);
    check({vidOe, presentOe, auxOe}, 3'h7);
    bus(1'b0, `VRX_REG_STATUS, 32'h0);
    check(q[1], 1'b1);
    $display("power done");
    results();
  end
endmodule : video_rx_ctrl_test

`default_nettype wire
